// File: src/fw_status_consts.svh
// Constants for the flash write-status poller: status bit positions,
// the reset command byte and the strobe timing of the flash bus.
// Assumes a byte-wide flash data bus and a 125 MHz controller clock.
`ifndef FW_STATUS_CONSTS_SVH
`define FW_STATUS_CONSTS_SVH

// Status bit positions on the data bus
`define FW_BIT_POLL      7
`define FW_BIT_TOGGLE1   6
`define FW_BIT_TLIMIT    5
`define FW_BIT_ETIMER    3
`define FW_BIT_TOGGLE2   2

// Reset command byte
`define FW_RESET_DATA    8'hf0

// Clock rate and strobe times
`define FW_CLK_MHZ       125
`define FW_RD_NS         90
`define FW_WR_NS         50
`define FW_GAP_NS        30

// Least times round up to whole cycles
`define FW_RD_CYC   (((`FW_RD_NS * `FW_CLK_MHZ) + 999) / 1000)
`define FW_WR_CYC   (((`FW_WR_NS * `FW_CLK_MHZ) + 999) / 1000)
`define FW_GAP_CYC  (((`FW_GAP_NS * `FW_CLK_MHZ) + 999) / 1000)

`endif

// File: src/fw_status_pkg.sv
// Types for the flash write-status poller.
// Widths follow an 18-bit byte address and an 8-bit data bus.
package fw_status_pkg;

  typedef logic [17:0] addr_t;
  typedef logic [7:0]  byte_t;
  typedef logic [4:0]  cnt_t;

  typedef enum logic [1:0] {
    cmd_poll   = 2'h0,
    cmd_status = 2'h1,
    cmd_reset  = 2'h2
  } cmd_t;

  typedef enum logic [3:0] {
    st_idle  = 4'h1,
    st_read  = 4'h2,
    st_write = 4'h4,
    st_gap   = 4'h8
  } state_t;

  typedef enum logic [2:0] {
    ph_first   = 3'h1,
    ph_second  = 3'h2,
    ph_recheck = 3'h4
  } phase_t;

  // Flash-side pins driven by the controller
  typedef struct packed {
    logic  ce_n;
    logic  oe_n;
    logic  we_n;
    logic  dq_oe;
    addr_t addr;
    byte_t dq_out;
  } pins_t;

  // Answer to one user request
  typedef struct packed {
    logic  ok;
    logic  fail;
    byte_t data;
  } result_t;

  // Whole controller state
  typedef struct packed {
    state_t  state;
    phase_t  phase;
    cmd_t    cmd;
    cnt_t    cnt;
    logic    fin;
    logic    wr_pend;
    byte_t   first;
    pins_t   pins;
    logic    ready;
    logic    done;
    logic    busy;
    result_t res;
  } ctl_t;

endpackage : fw_status_pkg

// File: src/flash_status_poller.sv
// Host-side controller that reads write-operation status from a parallel
// flash and runs the toggle-bit completion check on it.
// Assumes flash inputs are synchronous to clk; the data bus is two-way.
//
// How it works
// - Poll reads twice back to back; unchanged toggle bit means done.
// - Toggling with time limit high: recheck, still toggling means fail, reset.
// - Every new poll request restarts from the first double read.
// - After a time-limit failure the controller writes the reset command.
// - Erase timer may be skipped if added erases are under 50 us apart.
// - Software checks erase timer before and after each added sector erase; this controller never reads the erase-timer bit.
// - Status reads use the busy bank address; others return array data.
`timescale 1ns/1ps

`include "fw_status_consts.svh"

module flash_status_poller (
  input  wire logic                 clk,
  input  wire logic                 rst,
  input  wire logic                 en,
  input  wire logic                 req_valid,
  input  wire fw_status_pkg::cmd_t  req_cmd,
  input  wire fw_status_pkg::addr_t req_addr,
  output logic                      req_ready,
  output logic                      done,
  output fw_status_pkg::result_t    result,
  output logic                      bank_busy,
  output logic                      flash_ce_n,
  output logic                      flash_oe_n,
  output logic                      flash_we_n,
  output fw_status_pkg::addr_t      flash_addr,
  output fw_status_pkg::byte_t      flash_dq_out,
  output logic                      flash_dq_oe,
  input  wire fw_status_pkg::byte_t flash_dq_in,
  input  wire logic                 flash_ready_busy_n
);
  import fw_status_pkg::*;

  localparam cnt_t RD_CYC  = cnt_t'(`FW_RD_CYC);
  localparam cnt_t WR_CYC  = cnt_t'(`FW_WR_CYC);
  localparam cnt_t GAP_CYC = cnt_t'(`FW_GAP_CYC);

  // Strobes released, bus floated; address kept stable
  function automatic pins_t pins_quiet(input pins_t p);
    pins_t q;
    q        = p;
    q.ce_n   = 1'b1;
    q.oe_n   = 1'b1;
    q.we_n   = 1'b1;
    q.dq_oe  = 1'b0;
    q.dq_out = 8'h00;
    return q;
  endfunction : pins_quiet

  // Open a read cycle on both chip select and output enable
  function automatic ctl_t start_read(input ctl_t c);
    ctl_t q;
    q           = c;
    q.state     = st_read;
    q.cnt       = RD_CYC;
    q.pins.ce_n = 1'b0;
    q.pins.oe_n = 1'b0;
    return q;
  endfunction : start_read

  // Open a write cycle carrying the reset command byte
  function automatic ctl_t start_reset(input ctl_t c);
    ctl_t q;
    q             = c;
    q.state       = st_write;
    q.cnt         = WR_CYC;
    q.wr_pend     = 1'b0;
    q.pins.ce_n   = 1'b0;
    q.pins.we_n   = 1'b0;
    q.pins.dq_oe  = 1'b1;
    q.pins.dq_out = `FW_RESET_DATA;
    return q;
  endfunction : start_reset

  localparam ctl_t CTL_RST = '{
    state:   st_idle,
    phase:   ph_first,
    cmd:     cmd_poll,
    cnt:     '0,
    fin:     1'b0,
    wr_pend: 1'b0,
    first:   8'h00,
    pins:    '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, dq_oe: 1'b0,
               addr: 18'h00000, dq_out: 8'h00},
    ready:   1'b0,
    done:    1'b0,
    busy:    1'b0,
    res:     '0
  };

  ctl_t r;
  ctl_t next_r;
  logic tog_same;

  // Toggle bit compared between this read and the stored one
  assign tog_same = (flash_dq_in[`FW_BIT_TOGGLE1] == r.first[`FW_BIT_TOGGLE1]);

  // Next-state logic
  always_comb begin
    next_r      = r;
    next_r.done = 1'b0;
    next_r.busy = ~flash_ready_busy_n;
    case (r.state)
      st_idle: begin
        next_r.ready = 1'b1;
        if (req_valid && r.ready) begin
          next_r.ready     = 1'b0;
          next_r.cmd       = req_cmd;
          next_r.phase     = ph_first;
          next_r.fin       = 1'b0;
          next_r.res       = '0;
          next_r.pins.addr = req_addr;
          if (req_cmd == cmd_reset) begin
            next_r = start_reset(next_r);
          end else begin
            next_r = start_read(next_r);
          end
        end
      end
      st_read: begin
        if (r.cnt != '0) begin
          next_r.cnt = r.cnt - 5'h01;
        end else begin
          // Data is sampled at the end of the access window
          next_r.pins  = pins_quiet(r.pins);
          next_r.state = st_gap;
          next_r.cnt   = GAP_CYC;
          next_r.first = flash_dq_in;
          if (r.cmd != cmd_poll) begin
            next_r.res.ok   = 1'b1;
            next_r.res.data = flash_dq_in;
            next_r.fin      = 1'b1;
          end else begin
            case (r.phase)
              ph_first: begin
                next_r.phase = ph_second;
              end
              ph_second: begin
                if (tog_same) begin
                  next_r.res.ok   = 1'b1;
                  next_r.res.data = flash_dq_in;
                  next_r.fin      = 1'b1;
                end else if (flash_dq_in[`FW_BIT_TLIMIT]) begin
                  next_r.phase = ph_recheck;
                end
              end
              ph_recheck: begin
                next_r.res.data = flash_dq_in;
                if (tog_same) begin
                  next_r.res.ok = 1'b1;
                  next_r.fin    = 1'b1;
                end else begin
                  next_r.res.fail = 1'b1;
                  next_r.wr_pend  = 1'b1;
                end
              end
              default: begin
                next_r.phase = ph_first;
              end
            endcase
          end
        end
      end
      st_write: begin
        if (r.cnt != '0) begin
          next_r.cnt = r.cnt - 5'h01;
        end else begin
          // Data latches as the write strobe rises
          next_r.pins  = pins_quiet(r.pins);
          next_r.state = st_gap;
          next_r.cnt   = GAP_CYC;
          next_r.fin   = 1'b1;
          if (r.cmd == cmd_reset) begin
            next_r.res.ok = 1'b1;
          end
        end
      end
      st_gap: begin
        // Strobes stay high long enough for the flash to see a new read
        if (r.cnt != '0) begin
          next_r.cnt = r.cnt - 5'h01;
        end else if (r.fin) begin
          next_r.state = st_idle;
          next_r.done  = 1'b1;
          next_r.ready = 1'b1;
        end else if (r.wr_pend) begin
          next_r = start_reset(r);
        end else begin
          next_r = start_read(r);
        end
      end
      default: begin
        next_r = CTL_RST;
      end
    endcase
  end

  // State register; clock enable freezes everything
  always_ff @(posedge clk) begin
    if (rst) begin
      r <= CTL_RST;
    end else if (en) begin
      r <= next_r;
    end
  end

  // Outputs straight from the state register
  assign req_ready    = r.ready;
  assign done         = r.done;
  assign result       = r.res;
  assign bank_busy    = r.busy;
  assign flash_ce_n   = r.pins.ce_n;
  assign flash_oe_n   = r.pins.oe_n;
  assign flash_we_n   = r.pins.we_n;
  assign flash_addr   = r.pins.addr;
  assign flash_dq_out = r.pins.dq_out;
  assign flash_dq_oe  = r.pins.dq_oe;

endmodule : flash_status_poller

// File: dv/poll_properties.sv
// Checker: poller strobe shapes, read counts and poll outcomes.
// Assumes a bind to the poller's top ports, one clock domain.
`timescale 1ns/1ps
`include "fw_status_consts.svh"
module poll_checker (
  input wire logic                   clk,
  input wire logic                   rst,
  input wire logic                   en,
  input wire logic                   req_valid,
  input wire fw_status_pkg::cmd_t    req_cmd,
  input wire logic                   req_ready,
  input wire logic                   done,
  input wire fw_status_pkg::result_t result,
  input wire logic                   flash_ce_n,
  input wire logic                   flash_oe_n,
  input wire logic                   flash_we_n,
  input wire logic                   flash_dq_oe,
  input wire fw_status_pkg::byte_t   flash_dq_out
);
  import fw_status_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic       take;
  cmd_t       cur;
  logic [3:0] rds;
  // Reads counted per request, so a restart shows
  assign take = en && req_valid && req_ready;
  always_ff @(posedge clk) begin
    if (rst || take) begin
      rds <= 4'h0;
    end else if ($fell(flash_oe_n) && rds != 4'hf) begin
      rds <= rds + 4'h1;
    end
    if (take) begin
      cur <= req_cmd;
    end
  end
  rd_len_a: assert property ($fell(flash_oe_n) |-> (!flash_oe_n && !flash_ce_n)[*8]
    ##1 (!flash_oe_n)[*5] ##1 flash_oe_n) else $error("read length");
  rd_bus_a: assert property (!flash_oe_n |-> !flash_dq_oe && flash_we_n) else $error("bus");
  rst_cmd_a: assert property ($fell(flash_we_n) |-> flash_dq_oe && !flash_ce_n
    && flash_dq_out == `FW_RESET_DATA) else $error("reset byte");
  wr_end_a: assert property ($rose(flash_we_n) |-> ##[1:8] done) else $error("write end");
  two_reads_a: assert property (done && cur == cmd_poll |-> rds >= 4'h2) else $error("reads");
  fail_recheck_a: assert property (done && result.fail |-> cur == cmd_poll && rds >= 4'h3)
    else $error("recheck");
  first_read_a: assert property (take && req_cmd != cmd_reset |=> !flash_ce_n && !flash_oe_n)
    else $error("first read");
  stat_time_a: assert property (take && req_cmd == cmd_status |-> ##19 done && rds == 4'h1)
    else $error("status time");
  cover property (done && result.fail);
  cover property (done && result.ok && cur == cmd_poll);
  cover property (take && req_cmd == cmd_reset);
endmodule : poll_checker
bind flash_status_poller poll_checker chk_i (.clk(clk), .rst(rst), .en(en),
  .req_valid(req_valid), .req_cmd(req_cmd), .req_ready(req_ready), .done(done),
  .result(result), .flash_ce_n(flash_ce_n), .flash_oe_n(flash_oe_n),
  .flash_we_n(flash_we_n), .flash_dq_oe(flash_dq_oe), .flash_dq_out(flash_dq_out));

// File: dv/flash_bank_model.sv
// Bank model: a scripted program or erase, status shown on reads.
// Assumes strobes from the poller; ready/busy has a pull-up.
`timescale 1ns/1ps
`include "fw_status_consts.svh"
module flash_bank_model (
  input  wire logic                 ce_n,
  input  wire logic                 oe_n,
  input  wire logic                 we_n,
  input  wire fw_status_pkg::addr_t addr,
  input  wire fw_status_pkg::byte_t wdata,
  input  wire logic                 wdata_oe,
  output fw_status_pkg::byte_t      rdata,
  output logic                      rb_n
);
  import fw_status_pkg::*;
  int         left = 0;
  logic       stuck = 1'b0, tlim = 1'b0, tog = 1'b0, hit = 1'b0;
  logic [1:0] bank = 2'h0;
  byte_t      cur;
  // New operation; status valid at once
  task automatic start(int n, logic tl, logic st, logic [1:0] b);
    left = n;
    tlim = tl;
    stuck = st;
    bank = b;
    tog = 1'b0;
  endtask : start
  // Busy-bank reads flip both toggles; read counts stand in for time
  always @(negedge oe_n) begin
    #1;
    hit = !ce_n && addr[17:16] == bank && (left > 0 || stuck);
    if (hit) tog = ~tog;
    if (hit) left = left - 1;
  end
  // Reset write ends a failed operation; a running erase ignores it
  always @(negedge we_n) begin
    #1;
    if (!ce_n && wdata_oe && wdata == `FW_RESET_DATA && tlim) begin
      left = 0;
      stuck = 1'b0;
      tlim = 1'b0;
    end
  end
  // Erase layout, else array byte; a released bus shows the inverse
  assign cur = hit ? {1'b0, tog, tlim, 2'b01, tog, 2'b00} : 8'h1a;
  assign rdata = (ce_n || oe_n) ? ~cur : cur;
  assign rb_n = !(left > 0 || stuck);
endmodule : flash_bank_model

// File: dv/flash_status_poller_tb_top.sv
// Bench: poller against the scripted bank model.
// Assumes a 125 MHz clock and flash timing synchronous to it.
`timescale 1ns/1ps
module flash_status_poller_tb_top;
  import fw_status_pkg::*;
  logic    clk = 0, rst = 1, req_valid = 0;
  logic    req_ready, done, bank_busy, ce_n, oe_n, we_n, dq_oe, rb_n;
  cmd_t    req_cmd = cmd_poll;
  addr_t   req_addr = '0, fa;
  byte_t   dq_out, dq_in;
  result_t result;
  int      miscompares = 0, check_count = 0, cycles = 0;
  integer  seed = 32'h98e0;
  flash_status_poller uut (.clk(clk), .rst(rst), .en(1'b1), .req_valid(req_valid),
    .req_cmd(req_cmd), .req_addr(req_addr), .req_ready(req_ready), .done(done),
    .result(result), .bank_busy(bank_busy), .flash_ce_n(ce_n), .flash_oe_n(oe_n),
    .flash_we_n(we_n), .flash_addr(fa), .flash_dq_out(dq_out), .flash_dq_oe(dq_oe),
    .flash_dq_in(dq_in), .flash_ready_busy_n(rb_n));
  flash_bank_model dev (.ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .addr(fa), .wdata(dq_out),
    .wdata_oe(dq_oe), .rdata(dq_in), .rb_n(rb_n));
  always #4 clk = ~clk;
  task automatic report_and_stop();
    if (miscompares == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : report_and_stop
  // Hang guard, more than ten times the expected run
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      report_and_stop();
    end
  end
  task automatic chk(string w, logic [9:0] seen, logic [9:0] exp, logic [9:0] m);
    check_count++;
    if ((seen & m) !== (exp & m)) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", w, exp & m, seen & m);
    end
  endtask : chk
  // Byte at read k of a bank scripted with n toggling reads
  function automatic byte_t rv(int k, int n, logic tl, logic st, logic hit);
    return (hit && (st || k <= n)) ? {1'b0, k[0], tl, 2'b01, k[0], 2'b00} : 8'h1a;
  endfunction : rv
  function automatic result_t exp_poll(int n, logic tl, logic st, logic hit);
    byte_t p, c;
    p = rv(1, n, tl, st, hit);
    for (int k = 2; k < 64; k++) begin
      c = rv(k, n, tl, st, hit);
      if (p[6] == c[6]) return {2'b10, c};
      if (c[5]) begin
        p = rv(k + 1, n, tl, st, hit);
        return {p[6] == c[6], p[6] != c[6], p};
      end
      p = c;
    end
    return '0;
  endfunction : exp_poll
  task automatic op(cmd_t c, int n, logic tl, logic st, addr_t a, logic [1:0] b);
    logic    hit;
    result_t e;
    hit = a[17:16] == b;
    dev.start(n, tl, st, b);
    e = {2'b10, c == cmd_status ? rv(1, n, tl, st, hit) : 8'h00};
    if (c == cmd_poll) e = exp_poll(n, tl, st, hit);
    repeat (2) @(posedge clk);
    #1;
    chk("busy", bank_busy, n > 0 || st, 10'h001);
    while (req_ready !== 1'b1) begin
      @(posedge clk);
      #1;
    end
    req_valid = 1'b1;
    req_cmd = c;
    req_addr = a;
    @(posedge clk);
    #1;
    req_valid = 1'b0;
    while (done !== 1'b1) begin
      @(posedge clk);
      #1;
    end
    chk("result", result, e, c == cmd_reset ? 10'h300 : 10'h3ff);
    if (c != cmd_status) chk("idle", bank_busy,
      (n > 0 || st) && (c == cmd_poll ? !hit : !tl), 10'h001);
  endtask : op
  initial begin
    repeat (6) @(posedge clk);
    #1;
    rst = 1'b0;
    // Corners: done at once, long toggle, stuck, late stop, other bank, reset
    op(cmd_poll, 0, 1'b0, 1'b0, 18'h10000, 2'h1);
    op(cmd_poll, 6, 1'b0, 1'b0, 18'h3ff00, 2'h3);
    op(cmd_poll, 0, 1'b1, 1'b1, 18'h20040, 2'h2);
    op(cmd_poll, 2, 1'b1, 1'b0, 18'h00008, 2'h0);
    op(cmd_status, 3, 1'b0, 1'b0, 18'h10000, 2'h2);
    op(cmd_status, 3, 1'b1, 1'b0, 18'h2abcd, 2'h2);
    op(cmd_reset, 0, 1'b1, 1'b1, 18'h00000, 2'h0);
    repeat (24) op(cmd_t'($unsigned($random(seed)) % 3), $unsigned($random(seed)) % 7,
      1'($random(seed)), 1'b0, 18'($random(seed)), 2'($random(seed)));
    report_and_stop();
  end
endmodule : flash_status_poller_tb_top
